// [rtl/joy_ctrl.sv]
`timescale 1ns/1ns
module joy_ctrl
	import joy_ctrl_pkg::*;
#(
	parameter int CNT_WIDTH = CNT_W
) (
	input  wire logic                 CLK_SYS,
	input  wire logic                 NRST,
	input  wire logic [ADDR_W-1:0]    SA,
	input  wire logic                 IOR,
	input  wire logic                 IOW,
	input  wire logic [7:0]           SD_IN,
	output logic      [7:0]           SD_OUT,
	output logic                      SD_OE,
	input  wire logic [ADDR_W-1:0]    JOY_PORT_BASE,
	input  wire logic [ADDR_W-1:0]    CONTROL_GROUP_BASE,
	input  wire logic [3:0]           AXIS_POSITION_IN,
	input  wire logic [3:0]           BUTTON_IN,
	output logic                      AXIS_DISCHARGE,
	input  wire logic                 LINKED_IF_WRITE,
	input  wire logic                 CONTEXT_SWITCH,
	output logic                      CONTROL_IRQ,
	output logic                      MIXER_POWERDOWN,
	output logic                      MIXER_REG_RESET,
	output logic                      MIXER_VOLUME_FREEZE,
	output logic                      CONVERTER_POWERDOWN,
	output logic                      PROCESSOR_IDLE,
	output logic                      LINKED_IF_POWERDOWN,
	output logic                      CHIP_LOGIC_RESET
);

	// ==========================================================
	// state
	typedef struct packed {
		logic [3:0] pos_s1;
		logic [3:0] pos_s2;
		logic [3:0] btn_s1;
		logic [3:0] btn_s2;
		logic [3:0] axis_timer;
		logic       charging;
		logic [CNT_WIDTH-1:0] chg_cnt;
		logic [7:0] ctrl;
		logic       linked_asleep;
		logic       irq;
		logic [7:0] rdata;
		logic       oe;
		logic       iow_d;
		logic       ior_d;
	} state_t;

	state_t cur;
	state_t next_cur;

	// ==========================================================
	// decode helpers
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] base,
		input int bits);
		logic [ADDR_W-1:0] diff;
		logic              ok;
		diff = a - base;
		ok   = (a >= base) && (diff < 16'h0008);
		// upper bits beyond the decode width must be zero
		for (int i = 0; i < ADDR_W; i++) begin
			if (i >= bits && a[i])
				ok = 1'b0;
		end
		return ok;
	endfunction

	function automatic logic [2:0] ofs(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] b);
		logic [ADDR_W-1:0] d;
		d = a - b;
		return d[2:0];
	endfunction

	// sensing window: rate 00 slowest means the longest threshold
	function automatic logic [CNT_WIDTH-1:0] threshold(input logic [1:0] rate);
		logic [CNT_WIDTH-1:0] t;
		t = '0;
		t[CNT_WIDTH-1-rate] = 1'b1;
		return t;
	endfunction

	logic       joy_hit;
	logic       ctrl_hit;
	logic [2:0] joy_ofs;
	logic [2:0] ctrl_ofs;
	logic       wr_edge;
	logic       rd_edge;
	logic [1:0] pm;

	assign joy_hit  = hit(SA, JOY_PORT_BASE, JOY_DEC_BITS);
	assign ctrl_hit = hit(SA, CONTROL_GROUP_BASE, CTRL_DEC_BITS);
	assign joy_ofs  = ofs(SA, JOY_PORT_BASE);
	assign ctrl_ofs = ofs(SA, CONTROL_GROUP_BASE);
	assign wr_edge  = IOW && !cur.iow_d;
	assign rd_edge  = IOR && !cur.ior_d;
	assign pm       = cur.ctrl[F_PM_LO +: 2];

	// ==========================================================
	// next state
	always_comb begin
		next_cur        = cur;
		next_cur.iow_d  = IOW;
		next_cur.ior_d  = IOR;
		next_cur.pos_s1 = AXIS_POSITION_IN;
		next_cur.pos_s2 = cur.pos_s1;
		next_cur.btn_s1 = BUTTON_IN;
		next_cur.btn_s2 = cur.btn_s1;

		// timers end as each axis comparator trips, or at the rate window
		if (cur.charging) begin
			next_cur.chg_cnt    = cur.chg_cnt + 1'b1;
			next_cur.axis_timer = cur.axis_timer & ~cur.pos_s2;
			if (cur.chg_cnt == threshold(cur.ctrl[F_RATE_LO +: 2])) begin
				next_cur.charging   = 1'b0;
				next_cur.axis_timer = 4'h0;
			end
		end

		// mode 10 blocks this register; only the control register stays alive
		if (pm != PM_FULL_OFF && wr_edge && joy_hit && joy_ofs <= JOY_ALIAS_LAST) begin
			next_cur.axis_timer = 4'hF;
			next_cur.charging   = 1'b1;
			next_cur.chg_cnt    = '0;
		end
		if (wr_edge && ctrl_hit && ctrl_ofs == CTRL_REG_OFS) begin
			next_cur.ctrl = SD_IN;
			if (SD_IN[F_PROC_IDLE] || SD_IN[F_PM_LO +: 2] != PM_ACTIVE)
				next_cur.linked_asleep = 1'b1;
			else
				next_cur.linked_asleep = 1'b0;
		end else if (LINKED_IF_WRITE) begin
			next_cur.linked_asleep = 1'b0;
		end

		// cleared by disabling the enable or by mode 10, which wins over a set
		if (CONTEXT_SWITCH && cur.ctrl[F_CSW_IRQ])
			next_cur.irq = 1'b1;
		else if (!cur.ctrl[F_CSW_IRQ])
			next_cur.irq = 1'b0;

		next_cur.oe = 1'b0;
		if (rd_edge && ctrl_hit && ctrl_ofs == CTRL_REG_OFS) begin
			next_cur.oe    = 1'b1;
			next_cur.rdata = cur.ctrl;
		end else if (rd_edge && joy_hit && pm != PM_FULL_OFF) begin
			next_cur.oe = 1'b1;
			if (joy_ofs <= JOY_ALIAS_LAST)
				next_cur.rdata = {cur.btn_s2, cur.axis_timer};
			else
				next_cur.rdata = RSVD_READ;
		end else if (!IOR) begin
			next_cur.oe = 1'b0;
		end else begin
			next_cur.oe = cur.oe;
		end

		if (pm == PM_FULL_OFF) begin
			next_cur.axis_timer = 4'h0;
			next_cur.charging   = 1'b0;
			next_cur.irq        = 1'b0;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!NRST) begin
			cur        <= '0;
			cur.btn_s1 <= BTN_IDLE;
			cur.btn_s2 <= BTN_IDLE;
			cur.ctrl   <= CTRL_RESET;
		end else begin
			cur <= next_cur;
		end
	end

	// ==========================================================
	// outputs
	assign SD_OUT              = cur.rdata;
	assign SD_OE               = cur.oe;
	assign AXIS_DISCHARGE      = !cur.charging;
	assign CONTROL_IRQ         = cur.irq;
	// mode 01 overrides the mixer and converter bits
	assign MIXER_POWERDOWN     = (pm == PM_CONV_OFF) ? 1'b0 :
		(cur.ctrl[F_MIX_PD] || pm == PM_AUDIO_OFF);
	assign MIXER_REG_RESET     = (pm != PM_CONV_OFF) && cur.ctrl[F_MIX_PD];
	assign MIXER_VOLUME_FREEZE = (pm == PM_CONV_OFF);
	assign CONVERTER_POWERDOWN = (pm == PM_CONV_OFF) || (pm == PM_AUDIO_OFF) ||
		cur.ctrl[F_CONV_PD];
	assign PROCESSOR_IDLE      = cur.linked_asleep;
	assign LINKED_IF_POWERDOWN = cur.linked_asleep;
	assign CHIP_LOGIC_RESET    = (pm == PM_FULL_OFF);

	// ==========================================================
	// checks
	chk_write_starts: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		(wr_edge && joy_hit && joy_ofs <= JOY_ALIAS_LAST && pm != PM_FULL_OFF)
		|=> (cur.axis_timer == 4'hF && cur.charging))
		else $error("write did not start all timers");
	chk_read_layout: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		(rd_edge && joy_hit && !ctrl_hit && joy_ofs <= JOY_ALIAS_LAST && pm != PM_FULL_OFF)
		|=> (SD_OE && SD_OUT == {$past(cur.btn_s2), $past(cur.axis_timer)}))
		else $error("position read layout wrong");
	chk_high_decode: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		(|SA[ADDR_W-1:JOY_DEC_BITS]) |-> !joy_hit)
		else $error("joystick decoded with upper bits set");
	chk_ctrl_decode: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		(|SA[ADDR_W-1:CTRL_DEC_BITS]) |-> !ctrl_hit)
		else $error("control decoded with upper bits set");
	chk_timer_ends: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		(cur.charging && cur.chg_cnt == threshold(cur.ctrl[F_RATE_LO +: 2]) && !wr_edge)
		|=> (cur.axis_timer == 4'h0))
		else $error("timer outlived its window");
	chk_ctrl_readback: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		(wr_edge && ctrl_hit && ctrl_ofs == CTRL_REG_OFS) |=> (cur.ctrl == $past(SD_IN)))
		else $error("control readback mismatch");
	chk_irq_gate: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		!cur.ctrl[F_CSW_IRQ] |=> !CONTROL_IRQ)
		else $error("interrupt raised while disabled");
	chk_mode_one: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		(pm == PM_CONV_OFF) |-> (CONVERTER_POWERDOWN && !MIXER_POWERDOWN && MIXER_VOLUME_FREEZE))
		else $error("mode 01 outputs wrong");
	chk_mode_three: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		(pm == PM_AUDIO_OFF) |-> (CONVERTER_POWERDOWN && MIXER_POWERDOWN))
		else $error("mode 11 outputs wrong");
	chk_linked_wake: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		(LINKED_IF_WRITE && !(wr_edge && ctrl_hit && ctrl_ofs == CTRL_REG_OFS))
		|=> !LINKED_IF_POWERDOWN)
		else $error("linked interfaces did not wake");

	// ==========================================================
	// decode and read-back checks
	chk_alias_write: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		(wr_edge && joy_hit && joy_ofs > JOY_ALIAS_LAST && !cur.charging)
		|=> !cur.charging)
		else $error("upper joystick offset started timers");
	chk_top_read: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		(rd_edge && joy_hit && !ctrl_hit && joy_ofs > JOY_ALIAS_LAST && pm != PM_FULL_OFF)
		|=> (SD_OE && SD_OUT == RSVD_READ))
		else $error("upper joystick offset read wrong");
	chk_oe_release: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		!IOR |=> !SD_OE)
		else $error("data still driven after read strobe fell");
	chk_oe_hold: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		(IOR && SD_OE) |=> SD_OE)
		else $error("data dropped while read strobe high");
	chk_ctrl_other: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		(wr_edge && ctrl_hit && ctrl_ofs != CTRL_REG_OFS) |=> (cur.ctrl == $past(cur.ctrl)))
		else $error("control byte changed by another offset");
	chk_ctrl_read: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		(rd_edge && ctrl_hit && ctrl_ofs == CTRL_REG_OFS)
		|=> (SD_OE && SD_OUT == $past(cur.ctrl)))
		else $error("control read did not return written byte");

	// ==========================================================
	// axis timer checks
	chk_idle_clear: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		AXIS_DISCHARGE |-> (cur.axis_timer == 4'h0))
		else $error("timer bit high while discharged");
	chk_axis_fall: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		(cur.charging && !wr_edge)
		|=> ((cur.axis_timer & $past(cur.pos_s2)) == 4'h0))
		else $error("axis bit outlived its comparator");
	chk_no_rise: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		(cur.charging && !wr_edge)
		|=> ((cur.axis_timer & ~$past(cur.axis_timer)) == 4'h0))
		else $error("axis bit rose without a write");
	chk_no_start: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		(!wr_edge && !cur.charging) |=> !cur.charging)
		else $error("timers started without a write");

	// ==========================================================
	// power and interrupt checks
	chk_irq_set: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		(CONTEXT_SWITCH && cur.ctrl[F_CSW_IRQ] && pm != PM_FULL_OFF) |=> CONTROL_IRQ)
		else $error("context switch did not interrupt");
	chk_off_quiet: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		(pm == PM_FULL_OFF) |=> (!CONTROL_IRQ && AXIS_DISCHARGE))
		else $error("activity during full power down");
	chk_off_reset: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		(pm == PM_FULL_OFF) |-> CHIP_LOGIC_RESET)
		else $error("logic reset missing in full power down");
	chk_off_joy: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		(pm == PM_FULL_OFF && rd_edge && joy_hit && !ctrl_hit) |=> !SD_OE)
		else $error("joystick answered in full power down");
	chk_conv_bit: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		cur.ctrl[F_CONV_PD] |-> CONVERTER_POWERDOWN)
		else $error("converter bit ignored");
	chk_mix_bit: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		(cur.ctrl[F_MIX_PD] && pm != PM_CONV_OFF) |-> (MIXER_POWERDOWN && MIXER_REG_RESET))
		else $error("mixer bit ignored");
	chk_proc_sleep: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		(wr_edge && ctrl_hit && ctrl_ofs == CTRL_REG_OFS && SD_IN[F_PROC_IDLE])
		|=> PROCESSOR_IDLE)
		else $error("processor bit did not idle");
	chk_mode_zero: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		(pm == PM_ACTIVE && !cur.ctrl[F_CONV_PD])
		|-> (!CONVERTER_POWERDOWN && !MIXER_VOLUME_FREEZE && !CHIP_LOGIC_RESET))
		else $error("mode 00 not fully active");
	chk_mode_three_sleep: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		(wr_edge && ctrl_hit && ctrl_ofs == CTRL_REG_OFS && SD_IN[F_PM_LO +: 2] == PM_AUDIO_OFF)
		|=> LINKED_IF_POWERDOWN)
		else $error("mode 11 left linked interfaces up");
endmodule

// [rtl/joy_ctrl_pkg.sv]
package joy_ctrl_pkg;
	// ==========================================================
	// host address decode
	localparam int          JOY_DEC_BITS   = 10;
	localparam int          CTRL_DEC_BITS  = 12;
	localparam int          ADDR_W         = 16;
	localparam logic [2:0]  JOY_ALIAS_LAST = 3'h5;
	localparam logic [2:0]  JOY_RSVD_OFS   = 3'h6;
	localparam logic [2:0]  CTRL_REG_OFS   = 3'h0;
	// ==========================================================
	// control register fields
	localparam int          F_RATE_LO      = 0;
	localparam int          F_MIX_PD       = 2;
	localparam int          F_PROC_IDLE    = 3;
	localparam int          F_CONV_PD      = 4;
	localparam int          F_CSW_IRQ      = 5;
	localparam int          F_PM_LO        = 6;
	localparam logic [7:0]  CTRL_RESET     = 8'h00;
	localparam logic [7:0]  RSVD_READ      = 8'hFF;
	// ==========================================================
	// legacy power modes
	localparam logic [1:0]  PM_ACTIVE      = 2'h0;
	localparam logic [1:0]  PM_CONV_OFF    = 2'h1;
	localparam logic [1:0]  PM_FULL_OFF    = 2'h2;
	localparam logic [1:0]  PM_AUDIO_OFF   = 2'h3;
	// ==========================================================
	// axis timer: counter width sets the base threshold; buttons idle high
	localparam int          CNT_W          = 16;
	localparam logic [3:0]  BTN_IDLE       = 4'hF;
endpackage

// [tb/joy_stick_model.sv]
`timescale 1ns/1ns
module joy_stick_model (
	input  wire logic       clk,
	input  wire logic       discharge,
	input  wire logic [3:0] press,
	output logic      [3:0] position,
	output logic      [3:0] buttons
);
	// ==========================================
	// axes settle at spread times so each bit falls alone
	localparam int DELAY [4] = '{8, 30, 60, 90};
	int cnt = 0;
	always @(posedge clk) begin
		if (discharge) begin
			cnt <= 0;
		end else begin
			cnt <= cnt + 1;
		end
	end
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			position[i] = !discharge && (cnt >= DELAY[i]);
		end
	end
	assign buttons = ~press;
endmodule

// [tb/tb_joystick_port_and_power_control.sv]
`timescale 1ns/1ns
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin errors++; \
	$display("Error %s expected %h seen %h", n, e, s); end end
module tb_joystick_port_and_power_control;
	import joy_ctrl_pkg::*;
	localparam logic [15:0] JB = 16'h0200;
	localparam logic [15:0] CB = 16'h0120;
	logic        clk = 0, nrst = 0, ior = 0, iow = 0, lwr = 0, csw = 0;
	logic [15:0] sa = 16'h0000;
	logic [7:0]  sd_in = 8'h00, sd_out, d;
	logic        sd_oe, oe, disch, irq, mpd, mrr, mvf, cpd, pidle, lpd, clr;
	logic [3:0]  pos, btn, press = 4'h0;
	int          errors = 0, checks = 0;
	always #4 clk = ~clk;
	joy_ctrl #(.CNT_WIDTH(8)) joy_ctrl_inst (.CLK_SYS(clk), .NRST(nrst), .SA(sa), .IOR(ior),
		.IOW(iow), .SD_IN(sd_in), .SD_OUT(sd_out), .SD_OE(sd_oe), .JOY_PORT_BASE(JB),
		.CONTROL_GROUP_BASE(CB), .AXIS_POSITION_IN(pos), .BUTTON_IN(btn),
		.AXIS_DISCHARGE(disch), .LINKED_IF_WRITE(lwr), .CONTEXT_SWITCH(csw),
		.CONTROL_IRQ(irq), .MIXER_POWERDOWN(mpd), .MIXER_REG_RESET(mrr),
		.MIXER_VOLUME_FREEZE(mvf), .CONVERTER_POWERDOWN(cpd), .PROCESSOR_IDLE(pidle),
		.LINKED_IF_POWERDOWN(lpd), .CHIP_LOGIC_RESET(clr));
	joy_stick_model joy_stick_model_inst (.clk(clk), .discharge(disch), .press(press),
		.position(pos), .buttons(btn));
	// ==========================================
	// host bus cycles
	task wr(input logic [15:0] a, input logic [7:0] v);
		@(posedge clk) begin sa <= a; sd_in <= v; iow <= 1'b1; end
		@(posedge clk) iow <= 1'b0;
		@(posedge clk) #1;
	endtask
	task rd(input logic [15:0] a);
		@(posedge clk) begin sa <= a; ior <= 1'b1; end
		@(posedge clk);
		@(posedge clk) #1;
		d = sd_out;
		oe = sd_oe;
		@(posedge clk) ior <= 1'b0;
	endtask
	task pulse(input bit sw);
		@(posedge clk) if (sw) csw <= 1'b1; else lwr <= 1'b1;
		@(posedge clk) begin csw <= 1'b0; lwr <= 1'b0; end
		@(posedge clk) #1;
	endtask
	task end_sim;
		if (errors == 0 && checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// ==========================================
	// scenarios
	task t_timers;
		rd(CB); `CHK("ctrl reset", 8'h00, d)
		press <= 4'h5;
		wr(JB + 16'h3, 8'h00);
		rd(JB + 16'h5); `CHK("start", 8'hAF, d)
		repeat (20) @(posedge clk);
		rd(JB); `CHK("one axis", 8'hAE, d)
		repeat (120) @(posedge clk);
		rd(JB + 16'h1); `CHK("all done", 8'hA0, d)
		`CHK("discharge", 1'b1, disch)
	endtask
	task t_rate;
		wr(CB, 8'h03); wr(JB, 8'h00);
		repeat (20) @(posedge clk);
		rd(JB); `CHK("fast", 4'h0, d[3:0])
		wr(CB, 8'h02); wr(JB, 8'h00);
		repeat (20) @(posedge clk);
		rd(JB); `CHK("med fast", 4'hE, d[3:0])
		repeat (40) @(posedge clk);
	endtask
	task t_decode;
		rd(JB | 16'h0400); `CHK("joy alias", 1'b0, oe)
		rd(CB | 16'h1000); `CHK("ctrl alias", 1'b0, oe)
		rd(CB + 16'h1); `CHK("ctrl+1", 1'b0, oe)
	endtask
	task t_power;
		wr(CB, 8'h04); `CHK("mix pd", 2'h3, {mpd, mrr})
		wr(CB, 8'h10); `CHK("conv pd", 1'b1, cpd)
		wr(CB, 8'h44); `CHK("mode1", 3'h3, {mpd, cpd, mvf})
		wr(CB, 8'hC0); `CHK("mode3", 1'b1, lpd)
		wr(CB, 8'h80); `CHK("mode2", 1'b1, clr)
		wr(JB, 8'h00); `CHK("mode2 no start", 1'b1, disch)
		rd(JB); `CHK("mode2 joy", 1'b0, oe)
		rd(CB); `CHK("mode2 rb", 8'h80, d)
		wr(CB, 8'h00); `CHK("active", 4'h0, {clr, mpd, cpd, lpd})
	endtask
	task t_linked;
		wr(CB, 8'h08); `CHK("proc idle", 2'h3, {pidle, lpd})
		pulse(1'b0); `CHK("wake", 1'b0, lpd)
		rd(CB); `CHK("pdp rb", 8'h08, d)
		wr(CB, 8'h00);
	endtask
	task t_irq;
		pulse(1'b1); `CHK("irq off", 1'b0, irq)
		wr(CB, 8'h20);
		pulse(1'b1); `CHK("irq on", 1'b1, irq)
		wr(CB, 8'h00); `CHK("irq clr", 1'b0, irq)
	endtask
	initial begin
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		t_timers;
		t_rate;
		t_decode;
		t_power;
		t_linked;
		t_irq;
		end_sim;
	end
endmodule
